// *** hw/bws_regs.sv ***
// Bridge window registers, secondary status and forwarding decode
`timescale 1ns/1ns
module bws_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Secondary side events, one-cycle pulses
	input wire bws_pkg::bws_evt_type evt_i,
	// Transaction to classify
	input wire bws_pkg::bws_req_type req_i,
	// Forwarding decision, one cycle after the request
	output bws_pkg::bws_hit_type hit_o
);
	import bws_pkg::*;

	// Assertions sample on the rising edge and rest during reset
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ***********************************************************
	// Bus decode
	// ***********************************************************
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	wire req_w = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr_w = req_w & wb_we_i;
	wire sel_io = wb_adr_i == BWS_OFS_IO;
	wire sel_mem = wb_adr_i == BWS_OFS_MEM;
	wire sel_pf = wb_adr_i == BWS_OFS_PF;
	wire sel_pub = wb_adr_i == BWS_OFS_PF_UB;
	wire sel_pul = wb_adr_i == BWS_OFS_PF_UL;
	wire sel_iou = wb_adr_i == BWS_OFS_IO_UP;
	wire sel_ctl = wb_adr_i == BWS_OFS_CTL;
	wire [31:0] bmask;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign bmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
		end
	endgenerate
	wire [31:0] wmask = wb_dat_i & bmask;

	// ***********************************************************
	// Window registers
	// ***********************************************************
	logic [3:0] io_b_q, io_l_q;
	logic [15:0] io_ub_q, io_ul_q;
	logic [11:0] mem_b_q, mem_l_q, pf_b_q, pf_l_q;
	logic [31:0] pf_ub_q, pf_ul_q;
	logic [1:0] ctl_q;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [31:0] m);
		merge = (old & ~m) | (dat & m);
	endfunction

	wire [31:0] io_w = merge({16'h0000, io_l_q, BWS_IO32_CODE, io_b_q,
		BWS_IO32_CODE}, wb_dat_i, bmask);
	wire [31:0] mem_w = merge({mem_l_q, 4'h0, mem_b_q, 4'h0},
		wb_dat_i, bmask);
	wire [31:0] pf_w = merge({pf_l_q, BWS_PF64_CODE, pf_b_q,
		BWS_PF64_CODE}, wb_dat_i, bmask);
	wire [31:0] pub_w = merge(pf_ub_q, wb_dat_i, bmask);
	wire [31:0] pul_w = merge(pf_ul_q, wb_dat_i, bmask);
	wire [31:0] iou_w = merge({io_ul_q, io_ub_q}, wb_dat_i, bmask);
	wire [31:0] ctl_w = merge({30'h0, ctl_q}, wb_dat_i, bmask);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			io_b_q <= 4'h0;
			io_l_q <= 4'h0;
			io_ub_q <= 16'h0000;
			io_ul_q <= 16'h0000;
			mem_b_q <= 12'h000;
			mem_l_q <= 12'h000;
			pf_b_q <= 12'h000;
			pf_l_q <= 12'h000;
			pf_ub_q <= 32'h0000_0000;
			pf_ul_q <= 32'h0000_0000;
			ctl_q <= 2'h0;
		end else begin
			if (wr_w && sel_io) begin
				io_b_q <= io_w[7:4];
				io_l_q <= io_w[15:12];
			end
			if (wr_w && sel_mem) begin
				mem_b_q <= mem_w[15:4];
				mem_l_q <= mem_w[31:20];
			end
			if (wr_w && sel_pf) begin
				pf_b_q <= pf_w[15:4];
				pf_l_q <= pf_w[31:20];
			end
			if (wr_w && sel_pub)
				pf_ub_q <= pub_w;
			if (wr_w && sel_pul)
				pf_ul_q <= pul_w;
			if (wr_w && sel_iou) begin
				io_ub_q <= iou_w[15:0];
				io_ul_q <= iou_w[31:16];
			end
			if (wr_w && sel_ctl)
				ctl_q <= ctl_w[1:0];
		end
	end

	// Register write checks
	a_io_base_write: assert property (
		wr_w && sel_io && wb_sel_i[0] |=>
		io_b_q == $past(wb_dat_i[7:4]))
		else $error("I/O base write lost");
	a_io_limit_write: assert property (
		wr_w && sel_io && wb_sel_i[1] |=>
		io_l_q == $past(wb_dat_i[15:12]))
		else $error("I/O limit write lost");
	a_mem_base_write: assert property (
		wr_w && sel_mem && wb_sel_i[1:0] == 2'b11 |=>
		mem_b_q == $past(wb_dat_i[15:4]))
		else $error("Memory base write lost");
	a_mem_limit_write: assert property (
		wr_w && sel_mem && wb_sel_i[3:2] == 2'b11 |=>
		mem_l_q == $past(wb_dat_i[31:20]))
		else $error("Memory limit write lost");
	a_pf_base_write: assert property (
		wr_w && sel_pf && wb_sel_i[1:0] == 2'b11 |=>
		pf_b_q == $past(wb_dat_i[15:4]))
		else $error("Prefetch base write lost");
	a_pf_limit_write: assert property (
		wr_w && sel_pf && wb_sel_i[3:2] == 2'b11 |=>
		pf_l_q == $past(wb_dat_i[31:20]))
		else $error("Prefetch limit write lost");
	a_pf_upper_write: assert property (
		wr_w && sel_pub && wb_sel_i == 4'hf |=>
		pf_ub_q == $past(wb_dat_i))
		else $error("Prefetch base upper write lost");
	a_pf_ul_write: assert property (
		wr_w && sel_pul && wb_sel_i == 4'hf |=>
		pf_ul_q == $past(wb_dat_i))
		else $error("Prefetch limit upper write lost");
	a_io_upper_write: assert property (
		wr_w && sel_iou && wb_sel_i == 4'hf |=>
		{io_ul_q, io_ub_q} == $past(wb_dat_i))
		else $error("I/O upper write lost");
	a_ctl_write: assert property (
		wr_w && sel_ctl && wb_sel_i[0] |=>
		ctl_q == $past(wb_dat_i[1:0]))
		else $error("Control write lost");
	a_io_limit_keep: assert property (
		!(wr_w && sel_io) |=> $stable(io_l_q))
		else $error("I/O limit changed without write");
	a_mem_keep: assert property (
		!(wr_w && sel_mem) |=> $stable(mem_b_q) && $stable(mem_l_q))
		else $error("Memory window changed without write");

	// ***********************************************************
	// Secondary status flags
	// ***********************************************************
	wire wr_st = wr_w & sel_io;
	wire perr_set = evt_i.parity_err & ctl_q[BWS_CTL_PERR_EN];
	wire rse_set = evt_i.err_msg_sent & ctl_q[BWS_CTL_SERR_EN];
	logic mdpe_q, sta_q, rta_q, rma_q, rse_q, dpe_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mdpe_q <= 1'b0;
			sta_q <= 1'b0;
			rta_q <= 1'b0;
			rma_q <= 1'b0;
			rse_q <= 1'b0;
			dpe_q <= 1'b0;
		end else begin
			// Set wins over a same-cycle write-one clear
			mdpe_q <= perr_set |
				(mdpe_q & ~(wr_st & wmask[BWS_ST_MDPE]));
			sta_q <= sta_q | evt_i.cpl_abort_sent;
			rta_q <= rta_q | evt_i.cpl_abort_rcvd;
			rma_q <= rma_q | evt_i.cpl_unsup_rcvd;
			rse_q <= rse_set |
				(rse_q & ~(wr_st & wmask[BWS_ST_RSE]));
			dpe_q <= evt_i.poisoned_rcvd |
				(dpe_q & ~(wr_st & wmask[BWS_ST_DPE]));
		end
	end

	// Status flag checks
	a_sta_set: assert property (
		evt_i.cpl_abort_sent |=> sta_q)
		else $error("Signaled abort flag not set");
	a_rta_sticky: assert property (
		rta_q |=> rta_q)
		else $error("Received abort flag cleared");
	a_rma_sticky: assert property (
		rma_q |=> rma_q)
		else $error("Master abort flag cleared");
	a_rse_set: assert property (
		rse_set |=> rse_q)
		else $error("System error flag not set");
	a_dpe_set: assert property (
		evt_i.poisoned_rcvd |=> dpe_q)
		else $error("Poisoned flag not set");
	a_mdpe_clear: assert property (
		mdpe_q && wr_st && wmask[BWS_ST_MDPE] && !perr_set |=>
		!mdpe_q)
		else $error("Parity flag not cleared");
	a_rse_clear: assert property (
		rse_q && wr_st && wmask[BWS_ST_RSE] && !rse_set |=>
		!rse_q)
		else $error("System error flag not cleared");
	a_dpe_clear: assert property (
		dpe_q && wr_st && wmask[BWS_ST_DPE] && !evt_i.poisoned_rcvd |=>
		!dpe_q)
		else $error("Poisoned flag not cleared");

	// Bits 26:25, 23, 22, 21, 20:16 stay zero
	wire [15:0] status_w = {dpe_q, rse_q, rma_q, rta_q, sta_q, 2'b00,
		mdpe_q, 8'h00};

	// ***********************************************************
	// Read mux and acknowledge
	// ***********************************************************
	always_comb begin
		rdat_d = 32'h0000_0000;
		if (sel_io)
			rdat_d = {status_w, io_l_q, BWS_IO32_CODE, io_b_q,
				BWS_IO32_CODE};
		else if (sel_mem)
			rdat_d = {mem_l_q, 4'h0, mem_b_q, 4'h0};
		else if (sel_pf)
			rdat_d = {pf_l_q, BWS_PF64_CODE, pf_b_q,
				BWS_PF64_CODE};
		else if (sel_pub)
			rdat_d = pf_ub_q;
		else if (sel_pul)
			rdat_d = pf_ul_q;
		else if (sel_iou)
			rdat_d = {io_ul_q, io_ub_q};
		else if (sel_ctl)
			rdat_d = {30'h0, ctl_q};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req_w;
			rdat_q <= req_w ? rdat_d : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// Bus answer checks
	a_ack_follows_req: assert property (
		req_w |=> wb_ack_o)
		else $error("Request not acknowledged");
	a_dat_idle_zero: assert property (
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("Read data not zero outside acknowledge");
	a_mem_low_zero: assert property (
		wb_ack_o && $past(sel_mem) |->
		wb_dat_o[3:0] == 4'h0 && wb_dat_o[19:16] == 4'h0)
		else $error("Memory reserved bits not zero");

	// ***********************************************************
	// Window decode
	// ***********************************************************
	wire [31:0] io_base = {io_ub_q, io_b_q, 12'h000};
	wire [31:0] io_lim = {io_ul_q, io_l_q, BWS_IO_LOW_ONES};
	wire [31:0] mem_base = {mem_b_q, 20'h00000};
	wire [31:0] mem_lim = {mem_l_q, BWS_MEM_LOW_ONES};
	wire [63:0] pf_base = {pf_ub_q, pf_b_q, 20'h00000};
	wire [63:0] pf_lim = {pf_ul_q, pf_l_q, BWS_MEM_LOW_ONES};
	wire up_zero = req_i.addr[63:32] == 32'h0000_0000;
	wire io_in = up_zero && req_i.addr[31:0] >= io_base &&
		req_i.addr[31:0] <= io_lim;
	wire mem_in = up_zero && req_i.addr[31:0] >= mem_base &&
		req_i.addr[31:0] <= mem_lim;
	wire pf_in = req_i.addr >= pf_base &&
		req_i.addr <= pf_lim;
	bws_hit_type hit_q, hit_d;
	wire hit_io_w = req_i.valid & req_i.is_io & io_in;
	wire hit_mem_w = req_i.valid & ~req_i.is_io & mem_in;
	wire hit_pf_w = req_i.valid & ~req_i.is_io & pf_in;
	assign hit_d = {hit_io_w, hit_mem_w, hit_pf_w};

	always_ff @(posedge clk_i) begin
		if (rst_i)
			hit_q <= '0;
		else
			hit_q <= hit_d;
	end
	assign hit_o = hit_q;

	// Forwarding decision checks
	a_io_hit_taken: assert property (
		req_i.valid && req_i.is_io && up_zero &&
		req_i.addr[31:0] >= io_base && req_i.addr[31:0] <= io_lim |=>
		hit_o.io)
		else $error("I/O request inside window not forwarded");
	a_mem_hit_taken: assert property (
		req_i.valid && !req_i.is_io && up_zero &&
		req_i.addr[31:0] >= mem_base && req_i.addr[31:0] <= mem_lim |=>
		hit_o.mem)
		else $error("Memory request inside window not forwarded");
	a_pf_hit_taken: assert property (
		req_i.valid && !req_i.is_io &&
		req_i.addr >= pf_base && req_i.addr <= pf_lim |=> hit_o.pref)
		else $error("Prefetch request inside window not forwarded");
	a_mem_hit_range: assert property (
		hit_o.mem |-> $past(req_i.addr[63:32]) == 32'h0000_0000 &&
		$past(req_i.addr[31:0]) >= $past(mem_base) &&
		$past(req_i.addr[31:0]) <= $past(mem_lim))
		else $error("Memory hit outside window");
	a_pf_hit_range: assert property (
		hit_o.pref |-> $past(req_i.addr) >= $past(pf_base) &&
		$past(req_i.addr) <= $past(pf_lim))
		else $error("Prefetch hit outside window");
	a_io_hit_alone: assert property (
		hit_o.io |-> !hit_o.mem && !hit_o.pref)
		else $error("I/O hit also marked as memory");
	a_hit_needs_valid: assert property (
		!req_i.valid |=> hit_o == '0)
		else $error("Hit without valid request");

	// ***********************************************************
	// Assertions
	// ***********************************************************
	a_io_code_read: assert property (
		wb_ack_o && $past(sel_io) && !$past(wb_we_i) |->
		wb_dat_o[11:8] == BWS_IO32_CODE)
		else $error("I/O decode code wrong");
	a_pf_code_read: assert property (
		wb_ack_o && $past(sel_pf) && !$past(wb_we_i) |->
		wb_dat_o[3:0] == BWS_PF64_CODE &&
		wb_dat_o[19:16] == BWS_PF64_CODE)
		else $error("Prefetch decode code wrong");
	a_status_zero_bits: assert property (
		wb_ack_o && $past(sel_io) |->
		wb_dat_o[26:25] == 2'b00 && wb_dat_o[23:16] == 8'h00)
		else $error("Hardwired status bits not zero");
	a_mdpe_gated: assert property (
		!ctl_q[BWS_CTL_PERR_EN] && !mdpe_q |=> !mdpe_q)
		else $error("Parity flag set while disabled");
	a_mdpe_set: assert property (
		perr_set |=> mdpe_q)
		else $error("Parity flag not set");
	a_abort_sticky: assert property (
		sta_q |=> sta_q)
		else $error("Read-only abort flag cleared");
	a_rta_set: assert property (
		evt_i.cpl_abort_rcvd |=> rta_q)
		else $error("Received abort flag not set");
	a_rma_set: assert property (
		evt_i.cpl_unsup_rcvd |=> rma_q)
		else $error("Master abort flag not set");
	a_rse_gated: assert property (
		!ctl_q[BWS_CTL_SERR_EN] && !rse_q |=> !rse_q)
		else $error("System error flag set while disabled");
	a_dpe_clear_set: assert property (
		evt_i.poisoned_rcvd && wr_st && wmask[BWS_ST_DPE] |=> dpe_q)
		else $error("Poisoned set lost to clear");
	a_io_hit_range: assert property (
		hit_o.io |-> $past(req_i.addr[31:0]) <= $past(io_lim) &&
		$past(req_i.addr[31:0]) >= $past(io_base))
		else $error("I/O hit outside window");
	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held two cycles");

	c_io_hit: cover property (hit_o.io);
	c_pref_hit: cover property (hit_o.pref);
	c_dpe_clear: cover property (dpe_q ##1 !dpe_q);
	c_mem_write: cover property (wr_w && sel_mem ##1 wb_ack_o);
	c_set_wins: cover property (evt_i.poisoned_rcvd && wr_st &&
		wmask[BWS_ST_DPE]);
endmodule

// *** hw/bws_pkg.sv ***
// Constants and types for the bridge window and secondary status block
// Functional notes
// - I/O limit bits 11:8 always read 1h, meaning 32-bit I/O decode.
// - I/O limit bits 15:12 writable, low twelve address bits taken as FFFh.
// - I/O limit address bits 31:16 come from the upper limit field.
// - I/O base and limit decide forwarding of I/O transactions.
// - Status bits 21, 23 and 26:25 are hardwired to zero.
// - Bit 24 set on secondary parity error, write one clears, resets zero.
// - Bit 24 never sets while parity error response is disabled.
// - Bit 27 read-only, set when completing with completer abort.
// - Bit 28 read-only, set on received completer abort completion.
// - Bit 29 read-only, set on received unsupported request completion.
// - Bit 30 set on sent fatal/nonfatal message when report enable set.
// - Bit 31 set when secondary side receives a poisoned packet.
// - Memory base bits 15:4 writable, bits 3:0 zero, low bits zero.
// - Memory limit bits 31:20 writable, 19:16 zero, low bits FFFFFh.
// - Memory base and limit decide forwarding of memory transactions.
// - Prefetchable base bits 3:0 always read 1h, meaning 64-bit.
// - Prefetchable base bits 15:4 writable, upper half separate register.
// - Prefetchable base and limit decide forwarding of memory reads/writes.
// - Prefetchable base bits 63:32 held in separate writable register.
// - I/O limit bits 31:16 held in writable field at bits 31:16.
package bws_pkg;
	// ***********************************************************
	// Register offsets (byte addresses)
	// ***********************************************************
	localparam logic [7:0] BWS_OFS_IO = 8'h1c;
	localparam logic [7:0] BWS_OFS_MEM = 8'h20;
	localparam logic [7:0] BWS_OFS_PF = 8'h24;
	localparam logic [7:0] BWS_OFS_PF_UB = 8'h28;
	localparam logic [7:0] BWS_OFS_PF_UL = 8'h2c;
	localparam logic [7:0] BWS_OFS_IO_UP = 8'h30;
	localparam logic [7:0] BWS_OFS_CTL = 8'h40;

	// ***********************************************************
	// Field constants
	// ***********************************************************
	localparam logic [3:0] BWS_IO32_CODE = 4'h1;
	localparam logic [3:0] BWS_PF64_CODE = 4'h1;
	localparam logic [11:0] BWS_IO_LOW_ONES = 12'hfff;
	localparam logic [19:0] BWS_MEM_LOW_ONES = 20'hfffff;
	localparam int BWS_CTL_PERR_EN = 0;
	localparam int BWS_CTL_SERR_EN = 1;
	localparam int BWS_ST_MDPE = 24;
	localparam int BWS_ST_STA = 27;
	localparam int BWS_ST_RTA = 28;
	localparam int BWS_ST_RMA = 29;
	localparam int BWS_ST_RSE = 30;
	localparam int BWS_ST_DPE = 31;

	// ***********************************************************
	// Carrier types
	// ***********************************************************
	typedef struct packed {
		logic parity_err;
		logic cpl_abort_sent;
		logic cpl_abort_rcvd;
		logic cpl_unsup_rcvd;
		logic err_msg_sent;
		logic poisoned_rcvd;
	} bws_evt_type;

	typedef struct packed {
		logic valid;
		logic is_io;
		logic [63:0] addr;
	} bws_req_type;

	typedef struct packed {
		logic io;
		logic mem;
		logic pref;
	} bws_hit_type;
endpackage

// *** testbench/bws_far_model.sv ***
// Far side model: secondary-side event source and requester
`timescale 1ns/1ns
module bws_far_model (
	// Clock
	input wire logic clk_i,
	// Toward the block
	output bws_pkg::bws_evt_type evt_o,
	output bws_pkg::bws_req_type req_o
);
	import bws_pkg::*;
	initial begin
		evt_o = '0;
		req_o = '0;
	end
	task automatic pulse(input logic [5:0] e);
		@(posedge clk_i);
		evt_o <= e;
		@(posedge clk_i);
		evt_o <= '0;
	endtask
	// Released address lines show the inverse, never the old value
	task automatic send(input logic io, input logic [63:0] a);
		@(posedge clk_i);
		req_o <= {1'b1, io, a};
		@(posedge clk_i);
		req_o <= {1'b0, ~io, ~a};
		#1;
	endtask
endmodule

// *** testbench/test_bridge_window_and_secondary_status.sv ***
// Self-checking bench for the bridge window and status block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
	comparisons++; \
	if ((gt) !== (ex)) begin \
		$display("wrong value %s exp %h got %h", nm, ex, gt); \
		num_errors++; \
	end
module test_bridge_window_and_secondary_status;
	import bws_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	bws_evt_type evt;
	bws_req_type req;
	bws_hit_type hit_o;
	logic [31:0] rd;
	logic [31:0] ex;
	int pos[6] = '{24, 27, 28, 29, 30, 31};
	int num_errors = 0;
	int comparisons = 0;
	always #10 clk_i = ~clk_i;
	bws_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .evt_i(evt), .req_i(req), .hit_o(hit_o));
	bws_far_model far (.clk_i(clk_i), .evt_o(evt), .req_o(req));
	// ****************************************
	// Shared bus and decode tasks
	// ****************************************
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		`CHK("wb_ack_o", 1'b1, wb_ack_o)
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 4'hf, 32'h0);
		`CHK("wb_dat_o", e, rd)
	endtask
	task automatic probe(input logic io, input logic [63:0] a,
		input logic [2:0] e);
		far.send(io, a);
		`CHK("hit_o", e, hit_o)
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_access();
		rdc(BWS_OFS_IO, 32'h0000_0101);
		rdc(BWS_OFS_MEM, 32'h0);
		rdc(BWS_OFS_PF, 32'h0001_0001);
		rdc(BWS_OFS_PF_UB, 32'h0);
		rdc(BWS_OFS_IO_UP, 32'h0);
		wb(1'b1, BWS_OFS_IO, 4'hf, 32'hffff_ffff);
		rdc(BWS_OFS_IO, 32'h0000_f1f1);
		wb(1'b1, BWS_OFS_MEM, 4'hf, 32'hffff_ffff);
		rdc(BWS_OFS_MEM, 32'hfff0_fff0);
		wb(1'b1, BWS_OFS_PF, 4'hf, 32'hffff_ffff);
		rdc(BWS_OFS_PF, 32'hfff1_fff1);
		wb(1'b1, 8'h50, 4'hf, 32'hffff_ffff);
		rdc(8'h50, 32'h0);
	endtask
	task automatic t_windows();
		wb(1'b1, BWS_OFS_IO, 4'hf, 32'h0000_3020);
		wb(1'b1, BWS_OFS_IO_UP, 4'hf, 32'h0);
		probe(1'b1, 64'h2000, 3'b100);
		probe(1'b1, 64'h3fff, 3'b100);
		probe(1'b1, 64'h4000, 3'b000);
		probe(1'b1, 64'h1fff, 3'b000);
		wb(1'b1, BWS_OFS_IO_UP, 4'hf, 32'h0001_0000);
		probe(1'b1, 64'h1_3fff, 3'b100);
		probe(1'b1, 64'h1_4000, 3'b000);
		wb(1'b1, BWS_OFS_MEM, 4'hf, 32'h1000_1000);
		wb(1'b1, BWS_OFS_PF, 4'hf, 32'h2000_2000);
		wb(1'b1, BWS_OFS_PF_UB, 4'hf, 32'h1);
		wb(1'b1, BWS_OFS_PF_UL, 4'hf, 32'h1);
		probe(1'b0, 64'h1000_0000, 3'b010);
		probe(1'b0, 64'h100f_ffff, 3'b010);
		probe(1'b0, 64'h1010_0000, 3'b000);
		probe(1'b0, 64'h0fff_ffff, 3'b000);
		probe(1'b1, 64'h1000_0000, 3'b000);
		probe(1'b0, 64'h1_2000_0000, 3'b001);
		probe(1'b0, 64'h1_200f_ffff, 3'b001);
		probe(1'b0, 64'h2000_0000, 3'b000);
		probe(1'b0, 64'h1_2010_0000, 3'b000);
	endtask
	task automatic t_status();
		wb(1'b1, BWS_OFS_CTL, 4'hf, 32'h0);
		far.pulse(6'b100010);
		rdc(BWS_OFS_IO, 32'h0000_3121);
		wb(1'b1, BWS_OFS_CTL, 4'hf, 32'h3);
		rdc(BWS_OFS_CTL, 32'h3);
		ex = 32'h0000_3121;
		for (int i = 0; i < 6; i++) begin
			far.pulse(6'b100000 >> i);
			ex[pos[i]] = 1'b1;
			rdc(BWS_OFS_IO, ex);
		end
		wb(1'b1, BWS_OFS_IO, 4'hc, 32'hffff_0000);
		rdc(BWS_OFS_IO, 32'h3800_3121);
		// Events and write-one clear in one cycle: set wins
		fork
			far.pulse(6'b100011);
			wb(1'b1, BWS_OFS_IO, 4'h8, 32'hc100_0000);
		join
		rdc(BWS_OFS_IO, 32'hf900_3121);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(BWS_OFS_IO, 32'h0000_0101);
		rdc(BWS_OFS_MEM, 32'h0);
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_access();
		t_windows();
		t_status();
		print_verdict();
	end
endmodule
